// file: common/sysrp_pkg.sv
// Contract
// [RL1] Any of four sources asserts chip reset.
// [RL2] Hold reset until pin, oscillator, count, flash.
// [RL3] Fetch starts at address zero after release.
// [RL4] All registers hold reset values at release; only RST_N_I resets them, a reset from the four sources leaves them running.
// [RL5] First supply stage raises warning interrupt request.
// [RL6] Warning condition readable in a status bit.
// [RL7] Second supply stage forces reset, guarding flash.
// [RL8] Detector reset held, power-on takes over below.
// [RL9] Guard level decoded from flash pattern word.
// [RL10] Level one: no debug, limited programming, not sector 0.
// [RL11] Level two: no debug, full erase then update.
// [RL12] Level three: no debug, no programming, override ignored.
// [RL13] Thirty edge inputs plus one level wake input.
// [RL14] Vector table low 1 GB, 512-byte aligned.
// [RL15] Reset asserts asynchronously, releases synchronously; the four sources assert it only on an enabled clock edge.
package sysrp_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int WAKE_TIME_NS = 2560;
  localparam int WAKE_CYCLES = (WAKE_TIME_NS + CLK_PERIOD_NS - 1)
                               / CLK_PERIOD_NS;
  localparam int WAKE_CNT_W = 9;

  // ****************************************************************
  // Guard patterns held in the flash guard word
  // ****************************************************************
  localparam logic [31:0] GUARD_PAT_ONE = 32'h1234_5678;
  localparam logic [31:0] GUARD_PAT_TWO = 32'h8765_4321;
  localparam logic [31:0] GUARD_PAT_THREE = 32'h4321_8765;

  // ****************************************************************
  // Vector table placement
  // ****************************************************************
  localparam logic [31:0] RESET_FETCH_ADDR = 32'h0000_0000;
  localparam logic [31:0] VTOR_ALIGN_MASK = 32'h0000_01FF;
  localparam logic [31:0] VTOR_LIMIT_MASK = 32'hC000_0000;
  localparam int EDGE_IRQ_N = 30;

  typedef enum logic [1:0] {
    SYSRP_GUARD_NONE = 2'h0,
    SYSRP_GUARD_ONE = 2'h1,
    SYSRP_GUARD_TWO = 2'h2,
    SYSRP_GUARD_THREE = 2'h3
  } sysrp_guard_t;

  typedef enum logic [2:0] {
    SYSRP_ST_HOLD = 3'b001,
    SYSRP_ST_WAIT = 3'b010,
    SYSRP_ST_RUN = 3'b100
  } sysrp_state_t;

endpackage : sysrp_pkg

// file: common/sysrp_guard_if.sv
`timescale 1ns/1ps
interface sysrp_guard_if;
  import sysrp_pkg::*;
  logic [31:0] pattern;
  logic dbg_ok;
  logic isp_ok;
  logic isp_sector0_ok;
  logic isp_partial_ok;
  logic override_ok;
  sysrp_guard_t level;
  modport ctrl (output pattern, input dbg_ok, isp_ok, isp_sector0_ok,
                input isp_partial_ok, override_ok, level);
  modport dec (input pattern, output dbg_ok, isp_ok, isp_sector0_ok,
               output isp_partial_ok, override_ok, level);
endinterface : sysrp_guard_if

// file: src/sysrp_guard.sv
`timescale 1ns/1ps
module sysrp_guard
  import sysrp_pkg::*;
(
  sysrp_guard_if.dec g
);

  // ****************************************************************
  // Guard level decode
  // ****************************************************************
  wire is_one = (g.pattern == GUARD_PAT_ONE);
  wire is_two = (g.pattern == GUARD_PAT_TWO);
  wire is_three = (g.pattern == GUARD_PAT_THREE);

  // see [RL9]
  assign g.level = is_three ? SYSRP_GUARD_THREE :
                   is_two ? SYSRP_GUARD_TWO :
                   is_one ? SYSRP_GUARD_ONE : SYSRP_GUARD_NONE;
  // Debug port closes at every guarded level. see [RL10] see [RL11]
  assign g.dbg_ok = ~(is_one | is_two | is_three);
  assign g.isp_ok = ~is_three; // see [RL12]
  assign g.override_ok = ~is_three; // see [RL12]
  assign g.isp_sector0_ok = ~(is_one | is_three); // see [RL10]
  // Level two only allows erase-all then update. see [RL11]
  assign g.isp_partial_ok = ~(is_two | is_three);

endmodule : sysrp_guard

// file: src/sysrp_top.sv
`timescale 1ns/1ps
module sysrp_top
  import sysrp_pkg::*;
#(
  parameter int EDGE_N = EDGE_IRQ_N
) (
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  input wire logic CLK_EN_I,
  input wire logic PIN_RESET_N_I,
  input wire logic WDT_RESET_I,
  input wire logic POR_I,
  input wire logic SUPPLY_WARN_I,
  input wire logic SUPPLY_FAIL_I,
  input wire logic OSC_RUN_I,
  input wire logic FLASH_INIT_DONE_I,
  input wire logic [31:0] GUARD_WORD_I,
  input wire logic OVERRIDE_PIN_I,
  input wire logic IAP_REQ_I,
  input wire logic ISP_ERASE_ALL_I,
  input wire logic [EDGE_N-1:0] EDGE_IRQ_I,
  input wire logic [EDGE_N-1:0] EDGE_CLR_I,
  input wire logic LEVEL_IRQ_I,
  input wire logic LEVEL_WAKE_EN_I,
  input wire logic POWER_DOWN_I,
  input wire logic [31:0] VTOR_I,
  output logic CHIP_RST_N_O,
  output logic [31:0] FETCH_ADDR_O,
  output logic SUPPLY_WARN_IRQ_O,
  output logic SUPPLY_WARN_STAT_O,
  output logic [1:0] GUARD_LEVEL_O,
  output logic DBG_EN_O,
  output logic ISP_EN_O,
  output logic ISP_SECTOR0_EN_O,
  output logic ISP_PARTIAL_EN_O,
  output logic IAP_EN_O,
  output logic ISP_BOOT_O,
  output logic [EDGE_N-1:0] EDGE_PEND_O,
  output logic LEVEL_IRQ_O,
  output logic WAKE_O,
  output logic VTOR_OK_O
);

  // ****************************************************************
  // Reset synchroniser
  // ****************************************************************
  logic rst_s1_q;
  logic rst_s2_q;
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  wire rst_n = rst_s2_q;

  // ****************************************************************
  // Reset sources and release sequencing
  // ****************************************************************
  // Supply fail keeps reset down until power-on takes over. see [RL8]
  wire src_any = ~PIN_RESET_N_I | WDT_RESET_I | POR_I
                 | SUPPLY_FAIL_I; // see [RL1] see [RL7]
  wire release_ok = PIN_RESET_N_I & OSC_RUN_I
                    & FLASH_INIT_DONE_I; // see [RL2]
  localparam logic [WAKE_CNT_W-1:0] WAKE_LAST =
    WAKE_CNT_W'(WAKE_CYCLES - 1);

  sysrp_state_t state_q;
  sysrp_state_t state_d;
  logic [WAKE_CNT_W-1:0] cnt_q;
  wire cnt_done = (cnt_q == WAKE_LAST);

  always_comb begin
    state_d = state_q;
    case (state_q)
      SYSRP_ST_HOLD: if (!src_any) state_d = SYSRP_ST_WAIT;
      SYSRP_ST_WAIT: begin
        if (src_any) state_d = SYSRP_ST_HOLD;
        else if (cnt_done && release_ok) state_d = SYSRP_ST_RUN; // see [RL2]
      end
      SYSRP_ST_RUN: if (src_any) state_d = SYSRP_ST_HOLD; // see [RL1]
      default: state_d = SYSRP_ST_HOLD;
    endcase
  end

  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= SYSRP_ST_HOLD;
      cnt_q <= '0;
    end else if (CLK_EN_I) begin
      state_q <= state_d;
      if (state_q != SYSRP_ST_WAIT) cnt_q <= '0;
      else if (!cnt_done) cnt_q <= cnt_q + 1'b1;
    end
  end

  // Sources are seen by the clocked FSM so that release is always on
  // an edge; a slow clock enable delays release, never shortens it.
  wire run = (state_q == SYSRP_ST_RUN);
  wire run_d = (state_d == SYSRP_ST_RUN) & CLK_EN_I;

  // ****************************************************************
  // Code read guard
  // ****************************************************************
  sysrp_guard_if gif ();
  assign gif.pattern = GUARD_WORD_I;
  sysrp_guard u_guard (
    .g(gif)
  );

  // ****************************************************************
  // External interrupts
  // ****************************************************************
  logic [EDGE_N-1:0] edge_prev_q;
  logic [EDGE_N-1:0] edge_pend_q;
  wire [EDGE_N-1:0] edge_rise = EDGE_IRQ_I & ~edge_prev_q;

  generate
    for (genvar i = 0; i < EDGE_N; i++) begin : g_edge
      always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
          edge_prev_q[i] <= 1'b0;
          edge_pend_q[i] <= 1'b0;
        end else if (CLK_EN_I) begin
          edge_prev_q[i] <= EDGE_IRQ_I[i];
          // A new edge beats a clear in the same cycle. see [RL13]
          if (edge_rise[i]) edge_pend_q[i] <= 1'b1;
          else if (EDGE_CLR_I[i]) edge_pend_q[i] <= 1'b0;
        end
      end
    end
  endgenerate

  wire wake = LEVEL_IRQ_I & LEVEL_WAKE_EN_I & POWER_DOWN_I; // see [RL13]
  wire vtor_ok = ((VTOR_I & VTOR_ALIGN_MASK) == '0)
                 & ((VTOR_I & VTOR_LIMIT_MASK) == '0); // see [RL14]

  // ****************************************************************
  // Registered outputs
  // ****************************************************************
  // Every output takes its defined value while reset is held. see [RL4]
  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin // see [RL15]
      CHIP_RST_N_O <= 1'b0;
      FETCH_ADDR_O <= RESET_FETCH_ADDR;
      SUPPLY_WARN_IRQ_O <= 1'b0;
      SUPPLY_WARN_STAT_O <= 1'b0;
      GUARD_LEVEL_O <= SYSRP_GUARD_NONE;
      DBG_EN_O <= 1'b0;
      ISP_EN_O <= 1'b0;
      ISP_SECTOR0_EN_O <= 1'b0;
      ISP_PARTIAL_EN_O <= 1'b0;
      IAP_EN_O <= 1'b0;
      ISP_BOOT_O <= 1'b0;
      LEVEL_IRQ_O <= 1'b0;
      WAKE_O <= 1'b0;
      VTOR_OK_O <= 1'b0;
    end else if (CLK_EN_I) begin
      CHIP_RST_N_O <= run_d; // see [RL15]
      FETCH_ADDR_O <= RESET_FETCH_ADDR; // see [RL3]
      SUPPLY_WARN_IRQ_O <= SUPPLY_WARN_I & run; // see [RL5]
      SUPPLY_WARN_STAT_O <= SUPPLY_WARN_I; // see [RL6]
      GUARD_LEVEL_O <= gif.level; // see [RL9]
      DBG_EN_O <= gif.dbg_ok & run; // see [RL10]
      ISP_EN_O <= gif.isp_ok & run; // see [RL12]
      ISP_SECTOR0_EN_O <= gif.isp_sector0_ok & run; // see [RL10]
      // Level two unlocks updates only after an erase-all. see [RL11]
      ISP_PARTIAL_EN_O <= (gif.isp_partial_ok | ISP_ERASE_ALL_I) & run
                          & gif.isp_ok;
      IAP_EN_O <= IAP_REQ_I & run; // see [RL9]
      ISP_BOOT_O <= OVERRIDE_PIN_I & gif.override_ok; // see [RL12]
      LEVEL_IRQ_O <= LEVEL_IRQ_I;
      WAKE_O <= wake;
      VTOR_OK_O <= vtor_ok;
    end
  end

  assign EDGE_PEND_O = edge_pend_q;

endmodule : sysrp_top

// file: tb/sysrp_properties.sv
`timescale 1ns/1ps
module sysrp_properties
  import sysrp_pkg::*;
(
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  input wire logic CLK_EN_I,
  input wire logic PIN_RESET_N_I,
  input wire logic WDT_RESET_I,
  input wire logic POR_I,
  input wire logic SUPPLY_FAIL_I,
  input wire logic SUPPLY_WARN_I,
  input wire logic OSC_RUN_I,
  input wire logic FLASH_INIT_DONE_I,
  input wire logic CHIP_RST_N_O,
  input wire logic [31:0] FETCH_ADDR_O,
  input wire logic SUPPLY_WARN_STAT_O,
  input wire logic [1:0] GUARD_LEVEL_O,
  input wire logic DBG_EN_O,
  input wire logic ISP_EN_O,
  input wire logic ISP_BOOT_O
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);
  wire src = !PIN_RESET_N_I | WDT_RESET_I | POR_I | SUPPLY_FAIL_I;
  logic [9:0] quiet_q;
  // Saturates, so a long quiet run never wraps back below the wake count.
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) quiet_q <= '0;
    else if (src) quiet_q <= '0;
    else if (CLK_EN_I && quiet_q != 10'h3FF) quiet_q <= quiet_q + 1'b1;
  end
  a_any_source:
    assert property (CLK_EN_I && src |=> !CHIP_RST_N_O)
    else $error("reset source did not hold chip in reset");
  a_quiet_count:
    assert property ($rose(CHIP_RST_N_O) |-> quiet_q >= 10'h100)
    else $error("chip left reset before the wake count");
  a_run_needs_ok:
    assert property ($rose(CHIP_RST_N_O) |->
    $past(PIN_RESET_N_I && OSC_RUN_I && FLASH_INIT_DONE_I))
    else $error("chip left reset without release conditions");
  a_fetch_zero:
    assert property (CHIP_RST_N_O |-> FETCH_ADDR_O == RESET_FETCH_ADDR)
    else $error("fetch address not zero");
  a_warn_status:
    assert property (CHIP_RST_N_O && CLK_EN_I |=>
    SUPPLY_WARN_STAT_O == $past(SUPPLY_WARN_I))
    else $error("warning status does not follow detector");
  a_por_takes_over:
    assert property (POR_I |=> !CHIP_RST_N_O [*2])
    else $error("power-on request did not hold reset");
  a_guard_no_debug:
    assert property (GUARD_LEVEL_O != SYSRP_GUARD_NONE |-> !DBG_EN_O)
    else $error("debug open under a guard level");
  a_level3_closed:
    assert property (GUARD_LEVEL_O == SYSRP_GUARD_THREE |->
    !ISP_EN_O && !ISP_BOOT_O)
    else $error("programming open at guard level three");
  c_wake: cover property ($rose(CHIP_RST_N_O));
  c_warn: cover property (SUPPLY_WARN_STAT_O && CHIP_RST_N_O);
  c_level3: cover property (GUARD_LEVEL_O == SYSRP_GUARD_THREE);
endmodule // sysrp_properties

// file: tb/sysrp_partner.sv
`timescale 1ns/1ps
module sysrp_partner (
  input wire logic clk_i,
  input wire logic [15:0] mv_i,
  output logic warn_o,
  output logic fail_o,
  output logic por_o,
  output logic osc_o,
  output logic flash_o
);
  logic [3:0] ramp_q = 4'h0;
  // Flash start-up lags the oscillator, so release waits on both.
  always @(negedge clk_i) begin
    warn_o <= mv_i < 16'h0898;
    fail_o <= mv_i < 16'h073A;
    por_o <= mv_i < 16'h03E8;
    osc_o <= mv_i >= 16'h073A;
    ramp_q <= (mv_i < 16'h073A) ? 4'h0 : ramp_q + {3'h0, ramp_q != 4'hF};
    flash_o <= ramp_q == 4'hF;
  end
endmodule // sysrp_partner

// file: tb/tb.sv
`timescale 1ns/1ps
module tb;
  import sysrp_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, pin_n = 1'b1, wdt = 1'b0, in_application_programming = 1'b1;
  logic warn, fail, por, osc, fl, ovr = 1'b1, ers = 1'b0, lvl = 1'b0;
  logic [15:0] mv = 16'h0CE4;
  logic [31:0] gw = 32'h0000_0000, vt = 32'h0000_0000, fetch;
  logic [29:0] eirq = '0, eclr = '0, pend;
  logic chip, wirq, wst, dbg, in_system_programming, s0, part, iapo, boot, lirq, wake, vok;
  logic [1:0] glvl;
  logic ce = 1'b1, wen = 1'b1, pdn = 1'b1;
  int miscompares = 0, tests_run = 0, k;
  always #5 clk = ~clk;
  sysrp_partner sysrp_partner_i (.clk_i(clk), .mv_i(mv), .warn_o(warn),
    .fail_o(fail), .por_o(por), .osc_o(osc), .flash_o(fl));
  sysrp_top sysrp_top_i (.CORE_CLK_I(clk), .RST_N_I(rst_n), .CLK_EN_I(ce),
    .PIN_RESET_N_I(pin_n), .WDT_RESET_I(wdt), .POR_I(por),
    .SUPPLY_WARN_I(warn), .SUPPLY_FAIL_I(fail), .OSC_RUN_I(osc),
    .FLASH_INIT_DONE_I(fl), .GUARD_WORD_I(gw), .OVERRIDE_PIN_I(ovr),
    .IAP_REQ_I(in_application_programming), .ISP_ERASE_ALL_I(ers), .EDGE_IRQ_I(eirq),
    .EDGE_CLR_I(eclr), .LEVEL_IRQ_I(lvl), .LEVEL_WAKE_EN_I(wen),
    .POWER_DOWN_I(pdn), .VTOR_I(vt), .CHIP_RST_N_O(chip),
    .FETCH_ADDR_O(fetch), .SUPPLY_WARN_IRQ_O(wirq), .SUPPLY_WARN_STAT_O(wst),
    .GUARD_LEVEL_O(glvl), .DBG_EN_O(dbg), .ISP_EN_O(in_system_programming),
    .ISP_SECTOR0_EN_O(s0), .ISP_PARTIAL_EN_O(part), .IAP_EN_O(iapo),
    .ISP_BOOT_O(boot), .EDGE_PEND_O(pend), .LEVEL_IRQ_O(lirq),
    .WAKE_O(wake), .VTOR_OK_O(vok));
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wake_up();
    k = 0;
    while (chip !== 1'b1 && k < 400) begin
      cyc(1);
      k++;
    end
    chk("wake_span", 1, k >= 256 && k < 300);
    chk("fetch", RESET_FETCH_ADDR, fetch);
    chk("pending", 0, pend);
  endtask
  task automatic t_sources();
    for (int s = 0; s < 4; s++) begin
      pin_n = s != 0;
      wdt = s == 1;
      mv = (s == 2) ? 16'h0708 : (s == 3) ? 16'h0384 : 16'h0CE4;
      cyc(3);
      chk("chip_rst", 0, chip);
      pin_n = 1'b1;
      wdt = 1'b0;
      mv = 16'h0CE4;
      wake_up();
    end
  endtask
  task automatic t_warn();
    mv = 16'h0834;
    cyc(3);
    chk("warn", 32'h0000_0007, {wirq, wst, chip});
    mv = 16'h0CE4;
    cyc(3);
    chk("warn_off", 0, wst);
    chk("warn_irq_off", 0, wirq);
  endtask
  task automatic t_guard();
    logic [31:0] w [4] = '{32'h0000_0000, GUARD_PAT_ONE, GUARD_PAT_TWO,
      GUARD_PAT_THREE};
    for (int i = 0; i < 4; i++) begin
      gw = w[i];
      cyc(2);
      chk("level", i, glvl);
      chk("dbg", i == 0, dbg);
      chk("isp_boot", {i != 3, i != 3}, {in_system_programming, boot});
      chk("sector0", i == 0 || i == 2, s0);
      chk("iap", 1, iapo);
    end
    gw = GUARD_PAT_TWO;
    cyc(2);
    chk("partial", 0, part);
    ers = 1'b1;
    cyc(2);
    chk("partial_erased", 1, part);
  endtask
  task automatic t_irq();
    eirq[29] = 1'b1;
    lvl = 1'b1;
    cyc(2);
    chk("pend", 32'h2000_0000, pend);
    chk("level_wake", 3, {lirq, wake});
    wen = 1'b0;
    cyc(2);
    chk("wake_masked", 2, {lirq, wake});
    wen = 1'b1;
    pdn = 1'b0;
    cyc(2);
    chk("wake_awake", 2, {lirq, wake});
    pdn = 1'b1;
    eirq[29] = 1'b0;
    eclr[29] = 1'b1;
    cyc(1);
    eclr[29] = 1'b0;
    cyc(1);
    chk("pend_clr", 0, pend);
  endtask
  task automatic t_freeze();
    ce = 1'b0;
    pin_n = 1'b0;
    eirq[0] = 1'b1;
    cyc(3);
    chk("freeze_rst", 1, chip);
    chk("freeze_pend", 0, pend);
    pin_n = 1'b1;
    eirq[0] = 1'b0;
    ce = 1'b1;
    cyc(2);
    chk("thaw_rst", 1, chip);
  endtask
  task automatic t_vtor();
    logic [31:0] v [3] = '{32'h3FFF_FE00, 32'h0000_0100, 32'h4000_0000};
    for (int i = 0; i < 3; i++) begin
      vt = v[i];
      cyc(2);
      chk("vtor", i == 0, vok);
    end
  endtask
  task automatic final_report();
    if (miscompares == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #100_000;
    miscompares++;
    final_report();
  end
  initial begin
    cyc(16);
    rst_n = 1'b1;
    wake_up();
    t_sources();
    t_warn();
    t_guard();
    t_irq();
    t_vtor();
    t_freeze();
    final_report();
  end
endmodule // tb
bind sysrp_top sysrp_properties sysrp_properties_i (.*);
